// ### swa_pkg.sv
package swa_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_SAMPLE_NS   = 30000;
	localparam int T_PDH_NS      = 30000;
	localparam int T_PDL_NS      = 60000;
	localparam int T_ABORT_NS    = 120000;
	localparam int T_RST_NS      = 480000;

	// Least times round up to whole cycles.
	function automatic int ns_to_cyc(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int TMR_W = 13;
	localparam logic [TMR_W-1:0] SAMPLE_CYC   = TMR_W'(ns_to_cyc(T_SAMPLE_NS));
	localparam logic [TMR_W-1:0] PDH_CYC      = TMR_W'(ns_to_cyc(T_PDH_NS));
	localparam logic [TMR_W-1:0] PDL_CYC      = TMR_W'(ns_to_cyc(T_PDL_NS));
	localparam logic [TMR_W-1:0] PRES_END     = TMR_W'(PDH_CYC + PDL_CYC);
	localparam int               ABORT_CYC_DEF = ns_to_cyc(T_ABORT_NS);
	localparam int               RST_CYC_DEF   = ns_to_cyc(T_RST_NS);

	// ------------------------------------------------------------
	// Commands and memory layout
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ROM = 8'h33;
	localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
	localparam logic [7:0] CMD_RD_MEM   = 8'hf0;
	localparam logic [7:0] CMD_RD_CRC   = 8'hc3;
	localparam logic [7:0] CMD_RD_STAT  = 8'haa;
	localparam logic [7:0] CMD_WR_MEM   = 8'h0f;
	localparam logic [7:0] CMD_WR_STAT  = 8'h55;

	localparam int         MEM_BYTES  = 128;
	localparam int         STAT_BYTES = 8;
	localparam int         MEM_AW     = 8;
	localparam logic [4:0] PAGE_LAST  = 5'h1f;
	localparam logic [2:0] STAT_LAST  = 3'h7;
	localparam logic [2:0] ROM_LAST   = 3'h7;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [7:0] CRC_TAPS   = 8'h8c;
	localparam logic [7:0] CRC_INIT   = 8'h00;

	// ------------------------------------------------------------
	// Link phases
	// ------------------------------------------------------------
	typedef enum logic [9:0] {
		P_HALT   = 10'h001,
		P_PRES   = 10'h002,
		P_ROMCMD = 10'h004,
		P_ROMTX  = 10'h008,
		P_CMD    = 10'h010,
		P_ADDRLO = 10'h020,
		P_ADDRHI = 10'h040,
		P_CRCTX  = 10'h080,
		P_DATATX = 10'h100,
		P_DATARX = 10'h200
	} swa_phase_e;

	// One slot of the reflected x^8 + x^5 + x^4 + 1 generator.
	function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
		return {1'b0, c[7:1]} ^ ((c[0] ^ b) ? CRC_TAPS : 8'h00);
	endfunction

	function automatic logic [7:0] crc_rom(input logic [55:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 56; i++) begin
			c = crc_bit(c, d[i]);
		end
		return c;
	endfunction

endpackage

// ### swa_mem.sv
`timescale 1ns/100ps
`default_nettype none

module swa_mem #(
	parameter int DW    = 8,
	parameter int DEPTH = 136,
	parameter int AW    = 8
) (
	// Clock
	input  wire logic          core_clk,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW) || DW < 1) begin : g_chk
		$error("swa_mem: depth does not fit the address width.");
	end

	// Erased cells read as all ones, as an unprogrammed array would.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = '1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

`default_nettype wire

// ### swa_link.sv
// Functional notes
// - After the strobe the host owns the line in a write slot and the device in a read slot.
// - A low longer than 120 us may reset the device, so it abandons any transaction.
// - A low longer than 480 us resets the device, which then answers with a ready pulse.
// - In a read slot the device pulls the line low for a zero and leaves it released for a one.
// - A high line is idle, and a transaction may pause there and resume at any later time.
// - The top byte of the 64-bit identity ROM is the CRC of its lower 56 bits.
// - Every CRC on the link uses the generator x^8 + x^5 + x^4 + 1.
// - Write commands return a CRC over the received command, address and data bytes.
// - Read commands return a CRC over the received command and address bytes.
// - Page reads append a CRC after each page, and status reads one over the status field.
// - A CRC mismatch never stops or blocks the device's command sequence.
`timescale 1ns/100ps
`default_nettype none

module swa_link #(
	parameter logic [55:0] ROM_ID    = 56'h00_0000_0001_0001,
	parameter int          RST_CYC   = swa_pkg::RST_CYC_DEF,
	parameter int          ABORT_CYC = swa_pkg::ABORT_CYC_DEF
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Single-wire data line
	input  wire logic dq_in,
	output logic      dq_out,
	output logic      dq_oe,
	// Status
	output logic      bus_reset_pulse
);
	import swa_pkg::*;

	// ------------------------------------------------------------
	// Constants and checks
	// ------------------------------------------------------------
	localparam int          LOW_W     = $clog2(RST_CYC + 2);
	localparam logic [63:0] ROM_IMAGE = {crc_rom(ROM_ID), ROM_ID};
	localparam logic [LOW_W-1:0] RST_LIM   = LOW_W'(RST_CYC);
	localparam logic [LOW_W-1:0] ABORT_LIM = LOW_W'(ABORT_CYC);

	if (ABORT_CYC < 1 || ABORT_CYC >= RST_CYC) begin : g_chk
		$error("swa_link: abort time must be shorter than reset time.");
	end

	// Status bytes sit behind the main array in the same memory.
	function automatic logic [MEM_AW-1:0] mem_index(input logic [7:0] cmd,
			input logic [15:0] addr);
		if (cmd == CMD_RD_STAT || cmd == CMD_WR_STAT) begin
			return MEM_AW'(MEM_BYTES) + MEM_AW'(addr[2:0]);
		end
		return {1'b0, addr[6:0]};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	swa_phase_e       phase_r, phase_nxt;
	logic             dq_q_r, dq_q_nxt;
	logic [LOW_W-1:0] low_r, low_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic [7:0]       shreg_r, shreg_nxt;
	logic [7:0]       crc_r, crc_nxt;
	logic [2:0]       bit_r, bit_nxt;
	logic [2:0]       rom_r, rom_nxt;
	logic [7:0]       cmd_r, cmd_nxt;
	logic [15:0]      addr_r, addr_nxt;
	logic             ld_r, ld_nxt;
	logic             oe_r, oe_nxt;
	logic             rst_ev_r, rst_ev_nxt;

	logic             fall, rise, tx_mode, rx_mode, crc_hold, bit_ev, byte_ev, slot_bit;
	logic [7:0]       rx_byte, crc_upd, rd_data;
	logic             wr_en;

	assign dq_out          = 1'b0;
	assign dq_oe           = oe_r;
	assign bus_reset_pulse = rst_ev_r;

	swa_mem #(
		.DW    (8),
		.DEPTH (MEM_BYTES + STAT_BYTES),
		.AW    (MEM_AW)
	) u_mem (
		.core_clk (core_clk),
		.wr_en    (wr_en),
		.wr_addr  (mem_index(cmd_r, addr_r)),
		.wr_data  (rx_byte),
		.rd_addr  (mem_index(cmd_nxt, addr_nxt)),
		.rd_data  (rd_data)
	);

	// ------------------------------------------------------------
	// Slot decode
	// ------------------------------------------------------------
	always_comb begin
		fall     = dq_q_r & ~dq_in;
		rise     = ~dq_q_r & dq_in;
		tx_mode  = phase_r inside {P_ROMTX, P_CRCTX, P_DATATX};
		rx_mode  = phase_r inside {P_ROMCMD, P_CMD, P_ADDRLO, P_ADDRHI, P_DATARX};
		crc_hold = (phase_r == P_CRCTX);
		bit_ev   = (tx_mode | rx_mode) && (tmr_r == SAMPLE_CYC - 1'b1);
		byte_ev  = bit_ev && (bit_r == BIT_LAST);
		slot_bit = tx_mode ? shreg_r[0] : dq_in;
		rx_byte  = {dq_in, shreg_r[7:1]};
		crc_upd  = crc_hold ? crc_r : crc_bit(crc_r, slot_bit);
		wr_en    = byte_ev && (phase_r == P_DATARX);
	end

	// ------------------------------------------------------------
	// Link engine
	// ------------------------------------------------------------
	always_comb begin
		phase_nxt  = phase_r;
		dq_q_nxt   = dq_in;
		// Our own ready pulse is not a host low, so it never counts toward a reset.
		low_nxt    = (dq_in || phase_r == P_PRES) ? '0 : (low_r == '1 ? low_r : low_r + 1'b1);
		tmr_nxt    = tmr_r;
		shreg_nxt  = shreg_r;
		crc_nxt    = crc_r;
		bit_nxt    = bit_r;
		rom_nxt    = rom_r;
		cmd_nxt    = cmd_r;
		addr_nxt   = addr_r;
		ld_nxt     = 1'b0;
		rst_ev_nxt = 1'b0;

		// Slot timer starts at each host fall and parks at the sample point,
		// so outside the ready pulse an idle line leaves every counter and phase untouched.
		if (phase_r == P_PRES) begin
			tmr_nxt = tmr_r + 1'b1;
		end else if (fall) begin
			tmr_nxt = TMR_W'(1);
		end else if (tmr_r != '0 && tmr_r != SAMPLE_CYC) begin
			tmr_nxt = tmr_r + 1'b1;
		end

		if (ld_r) begin
			shreg_nxt = rd_data;
		end

		if (bit_ev) begin
			bit_nxt   = bit_r + 1'b1;
			crc_nxt   = crc_upd;
			shreg_nxt = tx_mode ? {1'b1, shreg_r[7:1]} : rx_byte;
		end

		if (byte_ev) begin
			unique case (phase_r)
				P_ROMCMD: begin
					crc_nxt = CRC_INIT;
					if (rx_byte == CMD_READ_ROM) begin
						phase_nxt = P_ROMTX;
						rom_nxt   = '0;
						shreg_nxt = ROM_IMAGE[7:0];
					end else if (rx_byte == CMD_SKIP_ROM) begin
						phase_nxt = P_CMD;
					end else begin
						phase_nxt = P_HALT;
					end
				end
				P_ROMTX: begin
					rom_nxt = rom_r + 1'b1;
					shreg_nxt = ROM_IMAGE[{rom_nxt, 3'b000} +: 8];
					if (rom_r == ROM_LAST) begin
						phase_nxt = P_CMD;
						crc_nxt   = CRC_INIT;
					end
				end
				P_CMD: begin
					cmd_nxt = rx_byte;
					phase_nxt = (rx_byte inside {CMD_RD_MEM, CMD_RD_CRC, CMD_RD_STAT,
						CMD_WR_MEM, CMD_WR_STAT}) ? P_ADDRLO : P_HALT;
				end
				P_ADDRLO: begin
					addr_nxt[7:0] = rx_byte;
					phase_nxt     = P_ADDRHI;
				end
				P_ADDRHI: begin
					addr_nxt[15:8] = rx_byte;
					if (cmd_r == CMD_WR_MEM || cmd_r == CMD_WR_STAT) begin
						phase_nxt = P_DATARX;
					end else begin
						phase_nxt = P_CRCTX;
						shreg_nxt = crc_upd;
					end
				end
				P_CRCTX: begin
					// The sequence moves on whatever the host made of the CRC.
					crc_nxt = CRC_INIT;
					if (cmd_r == CMD_WR_MEM || cmd_r == CMD_WR_STAT) begin
						phase_nxt = P_DATARX;
						addr_nxt  = addr_r + 1'b1;
					end else begin
						phase_nxt = P_DATATX;
						ld_nxt    = 1'b1;
					end
				end
				P_DATATX: begin
					addr_nxt = addr_r + 1'b1;
					if ((cmd_r == CMD_RD_CRC && addr_r[4:0] == PAGE_LAST) ||
						(cmd_r == CMD_RD_STAT && addr_r[2:0] == STAT_LAST)) begin
						phase_nxt = P_CRCTX;
						shreg_nxt = crc_upd;
					end else begin
						ld_nxt = 1'b1;
					end
				end
				P_DATARX: begin
					phase_nxt = P_CRCTX;
					shreg_nxt = crc_upd;
				end
				default: begin
					phase_nxt = P_HALT;
				end
			endcase
		end

		// Ready pulse: recovery gap, then a fixed low, then the ROM command.
		if (phase_r == P_PRES && tmr_r == PRES_END) begin
			phase_nxt = P_ROMCMD;
			bit_nxt   = '0;
			crc_nxt   = CRC_INIT;
			tmr_nxt   = '0;
		end

		// Our own ready pulse must not count as a host abort.
		if (rise && low_r > RST_LIM) begin
			phase_nxt  = P_PRES;
			tmr_nxt    = '0;
			rst_ev_nxt = 1'b1;
		end else if (!dq_in && low_r > ABORT_LIM && phase_r != P_PRES) begin
			phase_nxt = P_HALT;
		end

		// The device drives only in its own read slots and in the ready pulse.
		if (phase_r == P_PRES) begin
			oe_nxt = (tmr_r >= PDH_CYC) && (tmr_r < PRES_END);
		end else begin
			oe_nxt = tx_mode && !shreg_r[0] && !bit_ev &&
				(fall || (tmr_r != '0 && tmr_r < SAMPLE_CYC));
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_r  <= P_HALT;
			dq_q_r   <= 1'b1;
			low_r    <= '0;
			tmr_r    <= '0;
			shreg_r  <= '0;
			crc_r    <= CRC_INIT;
			bit_r    <= '0;
			rom_r    <= '0;
			cmd_r    <= '0;
			addr_r   <= '0;
			ld_r     <= 1'b0;
			oe_r     <= 1'b0;
			rst_ev_r <= 1'b0;
		end else begin
			phase_r  <= phase_nxt;
			dq_q_r   <= dq_q_nxt;
			low_r    <= low_nxt;
			tmr_r    <= tmr_nxt;
			shreg_r  <= shreg_nxt;
			crc_r    <= crc_nxt;
			bit_r    <= bit_nxt;
			rom_r    <= rom_nxt;
			cmd_r    <= cmd_nxt;
			addr_r   <= addr_nxt;
			ld_r     <= ld_nxt;
			oe_r     <= oe_nxt;
			rst_ev_r <= rst_ev_nxt;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_reset_presence: assert property (dq_in && !$past(dq_in) && $past(low_r) > RST_LIM
		|=> phase_r == P_PRES && bus_reset_pulse)
		else $error("Long low did not start the ready pulse.");
	a_abort_low: assert property (!dq_in && low_r > ABORT_LIM && phase_r != P_PRES
		|=> phase_r == P_HALT)
		else $error("Low beyond the abort time did not drop the transaction.");
	a_pres_gap: assert property (phase_r == P_PRES && $rose(dq_oe)
		|-> tmr_r == PDH_CYC + 1'b1)
		else $error("Ready pulse started at the wrong time.");
	a_pres_low: assert property (phase_r == P_PRES && tmr_r > PDH_CYC
		|-> dq_oe)
		else $error("Ready pulse released early.");
	a_read_zero: assert property (tx_mode && fall && !shreg_r[0] &&
		(tmr_r == '0 || tmr_r == SAMPLE_CYC) |=> dq_oe [*2])
		else $error("Read zero not driven low.");
	a_read_one: assert property (phase_r != P_PRES && (!tx_mode || shreg_r[0])
		|=> !dq_oe)
		else $error("Line driven outside a read zero.");
	a_crc_cmd_addr: assert property (byte_ev && phase_r == P_ADDRHI && cmd_r == CMD_RD_MEM
		|=> phase_r == P_CRCTX && shreg_r == crc_r)
		else $error("Command and address CRC not loaded for sending.");
	a_crc_write: assert property (byte_ev && phase_r == P_DATARX
		|=> phase_r == P_CRCTX && shreg_r == crc_r)
		else $error("Write CRC not returned after data byte.");
	a_page_crc: assert property (byte_ev && phase_r == P_DATATX && cmd_r == CMD_RD_CRC &&
		addr_r[4:0] == PAGE_LAST |=> phase_r == P_CRCTX)
		else $error("No CRC after a full page.");
	a_crc_continue: assert property (byte_ev && phase_r == P_CRCTX && dq_in
		|=> phase_r inside {P_DATATX, P_DATARX} && crc_r == CRC_INIT)
		else $error("Sequence stalled after a CRC.");
	a_idle_hold: assert property ((dq_in && tmr_r == SAMPLE_CYC && phase_r != P_PRES) [*8]
		|-> $stable(phase_r) && $stable(bit_r))
		else $error("State moved on an idle line.");

	c_presence: cover property (phase_r == P_PRES ##1 phase_r == P_ROMCMD);
	c_rom_read: cover property (byte_ev && phase_r == P_ROMTX && rom_r == ROM_LAST);
	c_page_crc: cover property (byte_ev && phase_r == P_CRCTX && cmd_r == CMD_RD_CRC);
	c_write: cover property (wr_en);

endmodule

`default_nettype wire

// ### swa_host.sv
`timescale 1ns/100ps
`default_nettype none

module swa_host (
	// Clock
	input  wire logic core_clk,
	// Shared data line
	input  wire logic line,
	output logic      host_low
);
	import swa_pkg::*;

	// ------------------------------------------------------------
	// Slot figures in cycles
	// ------------------------------------------------------------
	// The host samples a read bit well before the device's sample point.
	// The slot runs past that point, so the next fall is never ignored.
	localparam int STRB = 40;
	localparam int HSMP = 600;
	localparam int SLOT = 1250;

	initial host_low = 1'b0;

	task automatic hold_low(input int n);
		host_low <= 1'b1;
		repeat (n) @(posedge core_clk);
		host_low <= 1'b0;
	endtask

	task automatic slot(input logic wb, input logic rd, output logic rb);
		host_low <= 1'b1;
		for (int i = 1; i <= SLOT; i++) begin
			@(posedge core_clk);
			if (i == STRB && (wb || rd)) begin
				host_low <= 1'b0;
			end
			if (i == SLOT - 20) begin
				host_low <= 1'b0;
			end
			if (i == HSMP) begin
				rb = line;
			end
		end
		// An idle gap of random length must not disturb the transfer.
		repeat ($urandom % 16) @(posedge core_clk);
	endtask

	task automatic put_byte(input logic [7:0] b);
		logic d;
		for (int k = 0; k < 8; k++) slot(b[k], 1'b0, d);
	endtask

	task automatic get_byte(output logic [7:0] b);
		for (int k = 0; k < 8; k++) slot(1'b1, 1'b1, b[k]);
	endtask

endmodule

`default_nettype wire

// ### tb_one_wire_auth_link_crc.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_one_wire_auth_link_crc;
	import swa_pkg::*;

	// ------------------------------------------------------------
	// Setup
	// ------------------------------------------------------------
	// Counts shortened so the run stays short; the abort limit still exceeds a zero slot.
	localparam int          RST_N = 2000;
	localparam int          ABT_N = 1600;
	localparam logic [55:0] ROM_V = 56'h3c_9a51_e6d2_4b82; // Arbitrary identity value.

	logic       core_clk = 1'b0;
	logic       srst = 1'b1;
	logic       dq_out;
	logic       dq_oe;
	logic       bus_reset_pulse;
	logic       host_low;
	logic       line;
	logic [7:0] b;
	logic [7:0] lo;
	logic [7:0] dat;
	int         miscompares = 0;
	int         n_compared = 0;

	always #12.5 core_clk = ~core_clk;

	// Open-drain line with pull-up: low while either party pulls.
	assign line = (host_low || (dq_oe && !dq_out)) ? 1'b0 : 1'b1;

	swa_link #(.ROM_ID(ROM_V), .RST_CYC(RST_N), .ABORT_CYC(ABT_N)) DUT (
		.core_clk        (core_clk),
		.srst            (srst),
		.dq_in           (line),
		.dq_out          (dq_out),
		.dq_oe           (dq_oe),
		.bus_reset_pulse (bus_reset_pulse)
	);

	swa_host host (.core_clk(core_clk), .line(line), .host_low(host_low));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] crc_of(input logic [31:0] d, input int nbits);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			fb = c[0] ^ d[i];
			c = {1'b0, c[7:1]} ^ (fb ? 8'h8c : 8'h00);
		end
		return c;
	endfunction

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic bus_reset();
		int rise;
		int fall;
		rise = 0;
		fall = 0;
		host.hold_low(RST_N + 10);
		for (int n = 1; n <= 3700; n++) begin
			@(posedge core_clk);
			#1;
			if (n == 1) `CHK(bus_reset_pulse, 1'b1)
			if (n == 2) `CHK(bus_reset_pulse, 1'b0)
			if (dq_oe === 1'b1 && rise == 0) rise = n;
			if (dq_oe === 1'b0 && rise != 0 && fall == 0) fall = n;
		end
		`CHK(rise, int'(PDH_CYC) + 2)
		`CHK(fall - rise, int'(PDL_CYC))
		`CHK(dq_out, 1'b0)
		@(posedge core_clk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		void'($urandom(12972));
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);

		bus_reset();
		$display("test presence done");

		// A low between the abort and reset limits must drop the transfer silently.
		host.put_byte(CMD_READ_ROM);
		for (int k = 0; k < 4; k++) host.slot(1'b1, 1'b1, b[k]);
		`CHK(b[3:0], ROM_V[3:0])
		host.hold_low(ABT_N + 50);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(bus_reset_pulse, 1'b0)
		@(posedge core_clk);
		for (int k = 0; k < 4; k++) host.slot(1'b1, 1'b1, b[k]);
		`CHK(b[3:0], 4'hf)
		$display("test abort done");

		bus_reset();
		lo = 8'($urandom % STAT_BYTES);
		dat = 8'($urandom);
		host.put_byte(CMD_SKIP_ROM);
		host.put_byte(CMD_WR_STAT);
		host.put_byte(lo);
		host.put_byte(8'h00);
		host.put_byte(dat);
		host.get_byte(b);
		`CHK(b, crc_of({dat, 8'h00, lo, CMD_WR_STAT}, 32))
		$display("test status write crc done");

		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		wrap_up();
	end

endmodule

`default_nettype wire
